// *** rtl/pid_pkg.sv ***
/*
  constants for the parcel instruction decoder: field positions, widths,
  format codes and special operand values.
  assumes a single clock domain and an opcode class table supplied here.
*/
package pid_pkg;
  localparam int WORD_W = 64;
  localparam int PARCEL_W = 16;
  localparam int PARCELS = 4;
  localparam int PIDX_W = 2;
  // first parcel field positions, counted from the lsb (bit 0)
  localparam int G_HI = 15;
  localparam int G_LO = 12;
  localparam int H_HI = 11;
  localparam int H_LO = 9;
  localparam int I_HI = 8;
  localparam int I_LO = 6;
  localparam int J_HI = 5;
  localparam int J_LO = 3;
  localparam int K_HI = 2;
  localparam int K_LO = 0;
  localparam int OPC_W = 7;
  localparam int REG_W = 3;
  localparam int JK_W = 6;
  localparam int JKM_W = 22;
  localparam int IJKM_W = 24;
  localparam int ADDR_W = 22;
  // branch opcode using the combined jk form
  localparam logic [6:0] OPC_BRANCH_JK = 7'h05;
  // 4-bit g codes taking a second parcel (scalar memory, 24-bit constant)
  localparam logic [3:0] G_SMEM_LD = 4'h8;
  localparam logic [3:0] G_SMEM_ST = 4'h9;
  localparam logic [3:0] G_SMEM_ALD = 4'ha;
  localparam logic [3:0] G_SMEM_AST = 4'hb;
  localparam logic [3:0] G_IMM24 = 4'h1;
  // 7-bit gh codes taking a second parcel
  localparam logic [6:0] OPC_JUMP2 = 7'h06;
  localparam logic [6:0] OPC_RJUMP2 = 7'h07;
  localparam logic [6:0] OPC_COND_LO = 7'h08;
  localparam logic [6:0] OPC_COND_HI = 7'h0f;
  localparam logic [6:0] OPC_IMM22_A = 7'h10;
  localparam logic [6:0] OPC_IMM22_S = 7'h40;
  // 7-bit gh codes using the combined jk form (constants, mask, b/t); the shift codes have g = 4'ha, so they decode as two-parcel jkm
  localparam logic [6:0] OPC_JK_LO = 7'h11;
  localparam logic [6:0] OPC_JK_HI = 7'h1f;
  localparam logic [6:0] OPC_SHIFT_LO = 7'h50;
  localparam logic [6:0] OPC_SHIFT_HI = 7'h53;
  // special operand values for register zero in j or k
  localparam logic [63:0] A_J_ZERO = 64'h0;
  localparam logic [63:0] A_K_ZERO = 64'h1;
  localparam logic [63:0] S_J_ZERO = 64'h0;
  localparam logic [63:0] S_K_ZERO = 64'h8000_0000_0000_0000;
  typedef enum logic [3:0] {
    PID_FMT_DISCRETE = 4'h1,
    PID_FMT_COMBINED = 4'h2,
    PID_FMT_JKM = 4'h4,
    PID_FMT_IJKM = 4'h8
  } pid_fmt_t;
endpackage

// *** rtl/pid_field_split.sv ***
/*
  splits one first parcel (plus optional second parcel) into fields.
  purely combinational; the caller registers the results.
*/
`timescale 1ns/100ps
`default_nettype none
module pid_field_split (
  // parcels
  input wire logic [15:0] first,
  input wire logic [15:0] second,
  // fields
  output logic [6:0] opcode,
  output logic [2:0] fld_i,
  output logic [2:0] fld_j,
  output logic [2:0] fld_k,
  output logic [5:0] fld_jk,
  output logic [21:0] fld_jkm,
  output logic [23:0] fld_ijkm
);
  always_comb begin
    opcode = first[pid_pkg::G_HI:pid_pkg::H_LO];
    fld_i = first[pid_pkg::I_HI:pid_pkg::I_LO];
    fld_j = first[pid_pkg::J_HI:pid_pkg::J_LO];
    fld_k = first[pid_pkg::K_HI:pid_pkg::K_LO];
    fld_jk = first[pid_pkg::J_HI:pid_pkg::K_LO];
    fld_jkm = {first[pid_pkg::J_HI:pid_pkg::K_LO], second};
    // the i msb only tells branch from constant, so it stays out of the 24 bits
    fld_ijkm = {first[pid_pkg::I_HI-1:pid_pkg::K_LO], second};
  end
endmodule
`default_nettype wire

// *** rtl/pid_decoder.sv ***
/*
  parcel instruction decoder: takes 64-bit instruction words, walks them
  parcel by parcel and presents one decoded instruction per issue.
  assumes the fetch side holds word_data while word_valid and word_ready
  are not both high, and that issue_ready comes from the issue logic.
*/
`timescale 1ns/100ps
`default_nettype none
module pid_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction words from fetch
  input wire logic word_valid,
  input wire logic [63:0] word_data,
  input wire logic flush,
  input wire logic [1:0] flush_parcel,
  output logic word_ready,
  // decoded instruction to issue
  input wire logic issue_ready,
  output logic issue_valid,
  output logic two_parcel,
  output logic [3:0] format,
  output logic [6:0] opcode,
  output logic [2:0] fld_h,
  output logic [2:0] fld_i,
  output logic [2:0] fld_j,
  output logic [2:0] fld_k,
  output logic [5:0] fld_jk,
  output logic [21:0] fld_jkm,
  output logic [23:0] fld_ijkm,
  output logic [21:0] branch_word,
  output logic [1:0] branch_parcel,
  output logic branch_target_valid,
  output logic a_j_special,
  output logic a_k_special,
  output logic s_j_special,
  output logic s_k_special,
  output logic [63:0] a_j_value,
  output logic [63:0] a_k_value,
  output logic [63:0] s_j_value,
  output logic [63:0] s_k_value
);
  // does a first parcel need a second one
  function automatic logic needs_second(input logic [15:0] p);
    logic [6:0] gh;
    logic [3:0] g;
    gh = p[pid_pkg::G_HI:pid_pkg::H_LO];
    g = p[pid_pkg::G_HI:pid_pkg::G_LO];
    needs_second = (g == pid_pkg::G_SMEM_LD) || (g == pid_pkg::G_SMEM_ST) ||
                   (g == pid_pkg::G_SMEM_ALD) || (g == pid_pkg::G_SMEM_AST) ||
                   ((g == pid_pkg::G_IMM24) && p[pid_pkg::I_HI]) ||
                   (gh == pid_pkg::OPC_JUMP2) || (gh == pid_pkg::OPC_RJUMP2) ||
                   ((gh >= pid_pkg::OPC_COND_LO) && (gh <= pid_pkg::OPC_COND_HI)) ||
                   (gh == pid_pkg::OPC_IMM22_A) || (gh == pid_pkg::OPC_IMM22_S);
  endfunction

  function automatic pid_pkg::pid_fmt_t fmt_of(input logic [15:0] p);
    logic [6:0] gh;
    logic [3:0] g;
    gh = p[pid_pkg::G_HI:pid_pkg::H_LO];
    g = p[pid_pkg::G_HI:pid_pkg::G_LO];
    if ((g == pid_pkg::G_IMM24 && p[pid_pkg::I_HI]) || gh == pid_pkg::OPC_JUMP2 ||
        gh == pid_pkg::OPC_RJUMP2 ||
        (gh >= pid_pkg::OPC_COND_LO && gh <= pid_pkg::OPC_COND_HI)) begin
      fmt_of = pid_pkg::PID_FMT_IJKM;
    end else if (needs_second(p)) begin
      fmt_of = pid_pkg::PID_FMT_JKM;
    end else if (gh == pid_pkg::OPC_BRANCH_JK ||
                 (gh >= pid_pkg::OPC_JK_LO && gh <= pid_pkg::OPC_JK_HI) ||
                 (gh >= pid_pkg::OPC_SHIFT_LO && gh <= pid_pkg::OPC_SHIFT_HI)) begin
      fmt_of = pid_pkg::PID_FMT_COMBINED;
    end else begin
      fmt_of = pid_pkg::PID_FMT_DISCRETE;
    end
  endfunction

  // current word, its full flag and the parcel pointer
  logic [63:0] cur_word;
  logic cur_full;
  logic [1:0] ptr;
  logic [15:0] parcel [pid_pkg::PARCELS];

  // parcel 0 is the most significant quarter
  genvar gi;
  generate
    for (gi = 0; gi < pid_pkg::PARCELS; gi++) begin : g_split
      assign parcel[gi] = cur_word[63 - 16*gi -: 16];
    end
  endgenerate

  logic [15:0] first_p;
  logic need2;
  logic at_last;
  logic second_ok;
  logic [15:0] second_p;
  logic can_issue;
  logic out_free;
  assign first_p = parcel[ptr];
  assign need2 = needs_second(first_p);
  assign at_last = (ptr == 2'd3);
  // straddling instructions take parcel 0 of the incoming word, no padding
  assign second_ok = !at_last || word_valid;
  assign second_p = at_last ? word_data[63:48] : parcel[ptr + 2'd1];
  assign out_free = !issue_valid || issue_ready;
  assign can_issue = cur_full && out_free && !flush && (!need2 || second_ok);

  // words consumed: ptr walks past the end of cur_word
  logic [2:0] adv;
  logic [2:0] next_pos;
  logic leaving;
  assign adv = need2 ? 3'd2 : 3'd1;
  assign next_pos = {1'b0, ptr} + adv;
  assign leaving = can_issue && next_pos[2];
  assign word_ready = flush || !cur_full || leaving;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_word <= 64'h0;
      cur_full <= 1'b0;
      ptr <= 2'h0;
    end else if (flush) begin
      // a branch lands on any parcel of the word fetched after it
      cur_full <= word_valid;
      cur_word <= word_data;
      ptr <= flush_parcel;
    end else if (can_issue) begin
      ptr <= next_pos[1:0];
      if (next_pos[2]) begin
        cur_full <= word_valid;
        cur_word <= word_data;
      end
    end else if (!cur_full && word_valid) begin
      cur_full <= 1'b1;
      cur_word <= word_data;
    end
  end

  // split fields of the parcel(s) being issued
  logic [6:0] n_opc;
  logic [2:0] n_i;
  logic [2:0] n_j;
  logic [2:0] n_k;
  logic [5:0] n_jk;
  logic [21:0] n_jkm;
  logic [23:0] n_ijkm;
  pid_field_split u_split (
    .first(first_p),
    .second(need2 ? second_p : 16'h0),
    .opcode(n_opc),
    .fld_i(n_i),
    .fld_j(n_j),
    .fld_k(n_k),
    .fld_jk(n_jk),
    .fld_jkm(n_jkm),
    .fld_ijkm(n_ijkm)
  );

  pid_pkg::pid_fmt_t n_fmt;
  assign n_fmt = fmt_of(first_p);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      issue_valid <= 1'b0;
    end else if (flush) begin
      issue_valid <= 1'b0;
    end else if (out_free) begin
      issue_valid <= can_issue;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      two_parcel <= 1'b0;
      format <= 4'h0;
      opcode <= 7'h0;
      fld_h <= 3'h0;
      fld_i <= 3'h0;
      fld_j <= 3'h0;
      fld_k <= 3'h0;
      fld_jk <= 6'h0;
      fld_jkm <= 22'h0;
      fld_ijkm <= 24'h0;
      branch_word <= 22'h0;
      branch_parcel <= 2'h0;
      branch_target_valid <= 1'b0;
    end else if (can_issue) begin
      two_parcel <= need2;
      format <= n_fmt;
      opcode <= n_opc;
      fld_h <= n_opc[2:0]; // also the register designator under 4-bit opcodes
      fld_i <= n_i;
      fld_j <= n_j;
      fld_k <= n_k;
      fld_jk <= n_jk;
      fld_jkm <= n_jkm;
      fld_ijkm <= n_ijkm;
      // branch target: 22-bit word address then 2-bit parcel select
      branch_word <= n_ijkm[23:2];
      branch_parcel <= n_ijkm[1:0];
      branch_target_valid <= (n_fmt == pid_pkg::PID_FMT_IJKM) && !n_i[2];
    end
  end

  // register zero in j or k substitutes a constant and skips reservation;
  // the i field never does, so it keeps the real register contents
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_j_special <= 1'b0;
      a_k_special <= 1'b0;
      s_j_special <= 1'b0;
      s_k_special <= 1'b0;
      a_j_value <= 64'h0;
      a_k_value <= 64'h0;
      s_j_value <= 64'h0;
      s_k_value <= 64'h0;
    end else if (can_issue) begin
      a_j_special <= (n_j == 3'h0);
      a_k_special <= (n_k == 3'h0);
      s_j_special <= (n_j == 3'h0);
      s_k_special <= (n_k == 3'h0);
      a_j_value <= pid_pkg::A_J_ZERO;
      a_k_value <= pid_pkg::A_K_ZERO;
      s_j_value <= pid_pkg::S_J_ZERO;
      s_k_value <= pid_pkg::S_K_ZERO;
    end
  end
endmodule
`default_nettype wire

// *** verif/pid_decoder_properties.sv ***
/*
  concurrent checks on the decoder's issue port.
  assumes one clock domain; bound to every decoder instance.
*/
`timescale 1ns/100ps
`default_nettype none
module pid_decoder_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // handshake
  input wire logic flush,
  input wire logic issue_ready,
  input wire logic issue_valid,
  // decoded fields
  input wire logic two_parcel,
  input wire logic [3:0] format,
  input wire logic [6:0] opcode,
  input wire logic [2:0] fld_i,
  input wire logic [2:0] fld_j,
  input wire logic [2:0] fld_k,
  input wire logic [5:0] fld_jk,
  input wire logic [21:0] fld_jkm,
  input wire logic [23:0] fld_ijkm,
  input wire logic [21:0] branch_word,
  input wire logic [1:0] branch_parcel,
  input wire logic branch_target_valid,
  // special operands
  input wire logic a_j_special,
  input wire logic a_k_special,
  input wire logic [63:0] a_j_value,
  input wire logic [63:0] a_k_value,
  input wire logic [63:0] s_k_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_issue_hold: assert property (
    issue_valid && !issue_ready |=> issue_valid && $stable({opcode, fld_i, fld_j, fld_ijkm}))
    else $error("issue fields moved before taken");
  a_len_format: assert property (
    issue_valid |-> $onehot(format) && two_parcel == (format[2] | format[3]))
    else $error("length and format disagree");
  a_jk_joined: assert property (
    issue_valid |-> fld_jk == {fld_j, fld_k}) else $error("jk field wrong");
  a_jkm_joined: assert property (
    issue_valid && format == 4'h4 |-> fld_jkm[21:16] == {fld_j, fld_k})
    else $error("jkm field wrong");
  a_ijkm_joined: assert property (
    issue_valid && format == 4'h8 |-> fld_ijkm[23:16] == {fld_i[1:0], fld_j, fld_k})
    else $error("ijkm field wrong");
  a_target_split: assert property (
    issue_valid && branch_target_valid |-> !fld_i[2] && {branch_word, branch_parcel} == fld_ijkm)
    else $error("branch target wrong");
  a_branch_combined: assert property (
    issue_valid && opcode == 7'h05 |-> format == 4'h2) else $error("branch not combined");
  a_j_zero: assert property (
    issue_valid && a_j_special |-> fld_j == 3'h0 && a_j_value == 64'h0)
    else $error("j zero operand wrong");
  a_k_zero: assert property (
    issue_valid && a_k_special |-> fld_k == 3'h0 && a_k_value == 64'h1 &&
      s_k_value == 64'h8000_0000_0000_0000)
    else $error("k zero operand wrong");
  a_flush_clear: assert property (
    flush |=> !issue_valid) else $error("flush left an issue");
endmodule
bind pid_decoder pid_decoder_properties pid_decoder_properties_i (.*);
`default_nettype wire

// *** verif/pid_fetch_model.sv ***
/*
  fetch-side model: offers pushed words in order on the fetch bus.
  assumes the bench pushes no more than 15 words ahead.
*/
`timescale 1ns/100ps
`default_nettype none
module pid_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bench side
  input wire logic push,
  input wire logic [63:0] push_word,
  // fetch bus
  input wire logic word_ready,
  output logic word_valid,
  output logic [63:0] word_data
);
  logic [63:0] mem [0:15];
  logic [3:0] rd;
  logic [3:0] wr;
  logic [63:0] last;
  assign word_valid = rd != wr;
  // an idle bus shows the inverse of the last word so stale data never matches
  assign word_data = word_valid ? mem[rd] : ~last;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd <= 4'h0;
      last <= 64'h0;
    end else if (word_valid && word_ready) begin
      rd <= rd + 4'h1;
      last <= mem[rd];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr <= 4'h0;
    end else if (push) begin
      mem[wr] <= push_word;
      wr <= wr + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
/*
  bench for the parcel decoder: words enter through the fetch model,
  each issued instruction is held, checked, then taken.
  assumes the decoder needs a handshake per issued instruction.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic push = 1'b0;
  logic [63:0] push_word = 64'h0;
  logic flush = 1'b0;
  logic [1:0] flush_parcel = 2'h0;
  logic issue_ready = 1'b0;
  logic word_valid, word_ready, issue_valid, two_parcel, branch_target_valid;
  logic a_j_special, a_k_special, s_j_special, s_k_special;
  logic [63:0] word_data, a_j_value, a_k_value, s_j_value, s_k_value;
  logic [3:0] format;
  logic [6:0] opcode;
  logic [2:0] fld_h, fld_i, fld_j, fld_k;
  logic [5:0] fld_jk;
  logic [21:0] fld_jkm, branch_word;
  logic [23:0] fld_ijkm;
  logic [1:0] branch_parcel;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  pid_decoder pid_decoder_i (.*);
  pid_fetch_model pid_fetch_model_i (.*);
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic put(input logic [63:0] w);
    push <= 1'b1;
    push_word <= w;
    @(posedge clk);
    push <= 1'b0;
  endtask
  // waits for one issue, checks it against parcel p, second parcel m, format f
  task automatic pop(input logic [15:0] p, input logic [15:0] m, input logic [3:0] f);
    int n;
    logic tgt;
    n = 0;
    tgt = f == 4'h8 && !p[8];
    do begin
      @(negedge clk);
      n++;
    end while (issue_valid !== 1'b1 && n < 40);
    chk("valid", issue_valid, 1'b1);
    chk("fields", {opcode, fld_i, fld_j, fld_k}, p);
    chk("h", fld_h, p[11:9]);
    chk("jk", fld_jk, p[5:0]);
    chk("format", {two_parcel, format}, {f[3] | f[2], f});
    chk("special", {a_j_special, a_k_special, s_j_special, s_k_special},
        {p[5:3] == 3'h0, p[2:0] == 3'h0, p[5:3] == 3'h0, p[2:0] == 3'h0});
    chk("a_j_value", a_j_value, 64'h0);
    chk("a_k_value", a_k_value, 64'h1);
    chk("s_j_value", s_j_value, 64'h0);
    chk("s_k_value", s_k_value, 64'h8000_0000_0000_0000);
    if (f == 4'h4) chk("jkm", fld_jkm, {p[5:0], m});
    if (f == 4'h8) chk("ijkm", fld_ijkm, {p[7:0], m});
    chk("tgt_valid", branch_target_valid, tgt);
    if (tgt) chk("target", {branch_word, branch_parcel}, {p[7:0], m});
    @(posedge clk);
    issue_ready <= 1'b1;
    @(posedge clk);
    issue_ready <= 1'b0;
  endtask
  task automatic t_discrete();
    put(64'h4053_5e00_6a91_f247);
    pop(16'h4053, 16'h0, 4'h1);
    pop(16'h5e00, 16'h0, 4'h1);
    pop(16'h6a91, 16'h0, 4'h1);
    pop(16'hf247, 16'h0, 4'h1);
    $display("test discrete done");
  endtask
  // last instruction straddles the word; next word arrives late on purpose
  task automatic t_span();
    put(64'h0aed_0c9a_1234_2155);
    pop(16'h0aed, 16'h0, 4'h2);
    pop(16'h0c9a, 16'h1234, 4'h8);
    repeat (6) @(negedge clk);
    chk("stall", issue_valid, 1'b0);
    @(posedge clk);
    put(64'hbeef_1b6c_5678_22d7);
    pop(16'h2155, 16'hbeef, 4'h4);
    pop(16'h1b6c, 16'h5678, 4'h8);
    pop(16'h22d7, 16'h0, 4'h2);
    $display("test span done");
  endtask
  task automatic t_flush();
    put(64'h4053_5e00_8abc_0042);
    flush <= 1'b1;
    flush_parcel <= 2'h2;
    @(posedge clk);
    flush <= 1'b0;
    pop(16'h8abc, 16'h0042, 4'h4);
    $display("test flush done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_discrete();
    t_span();
    t_flush();
    give_verdict();
  end
  // the tests need well under 200 cycles; 1000 leaves a wide margin
  initial begin
    #4000;
    error_cnt++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
